/* inc/nvs_pkg.sv */
// Constants, types and timing for the store/recall sequencer
// Assumes a single 50 MHz clock; every time is converted to cycles here
package nvs_pkg;

    // ==================================================================
    // Clock and unit scale
    localparam int CLK_NS    = 20;
    localparam int NS_PER_US = 1000;
    localparam int NS_PER_MS = 1_000_000;

    // ==================================================================
    // Times as printed
    localparam int T_FA_MS      = 20;
    localparam int T_FA_LV_MS   = 40;
    localparam int T_STORE_MS   = 8;
    localparam int T_RECALL_US  = 600;
    localparam int T_DELAY_NS   = 25;
    localparam int T_HHHD_NS    = 500;
    localparam int T_LZHSB_US   = 5;
    localparam int T_WAKE_MS    = 20;
    localparam int T_WAKE_LV_MS = 40;
    localparam int T_SLEEP_MS   = 8;
    localparam int T_SB_US      = 100;

    // Longest time to cycles, rounded down, at least one
    function automatic int cyc_max(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // ==================================================================
    // Cycle counts
    localparam int C_FA_CYC      = cyc_max(T_FA_MS * NS_PER_MS);
    localparam int C_FA_LV_CYC   = cyc_max(T_FA_LV_MS * NS_PER_MS);
    localparam int C_STORE_CYC   = cyc_max(T_STORE_MS * NS_PER_MS);
    localparam int C_RECALL_CYC  = cyc_max(T_RECALL_US * NS_PER_US);
    localparam int C_DELAY_CYC   = cyc_max(T_DELAY_NS);
    localparam int C_HHHD_CYC    = cyc_max(T_HHHD_NS);
    localparam int C_LZHSB_CYC   = cyc_max(T_LZHSB_US * NS_PER_US);
    localparam int C_WAKE_CYC    = cyc_max(T_WAKE_MS * NS_PER_MS);
    localparam int C_WAKE_LV_CYC = cyc_max(T_WAKE_LV_MS * NS_PER_MS);
    localparam int C_SLEEP_CYC   = cyc_max(T_SLEEP_MS * NS_PER_MS);
    localparam int C_SB_CYC      = cyc_max(T_SB_US * NS_PER_US);

    // ==================================================================
    // Synchroniser lanes
    localparam int SYNC_W    = 4;
    localparam int LANE_SUP  = 0;
    localparam int LANE_PIN  = 1;
    localparam int LANE_SCL  = 2;
    localparam int LANE_SDA  = 3;

    // ==================================================================
    // Types
    typedef struct packed {
        logic store;
        logic recall;
        logic sleep;
        logic wake;
    } nvs_cmd_t;

    typedef struct packed {
        logic host_en;
        logic sram_wen;
        logic busy;
        logic low_power;
        logic standby;
    } nvs_stat_t;

    typedef enum logic [3:0] {
        S_PWRDN,
        S_RECALL,
        S_READY,
        S_DELAY,
        S_STORE,
        S_HIGH,
        S_PINWAIT,
        S_SLP_ENTER,
        S_SLEEP,
        S_WAKE
    } nvs_state_t;

endpackage

/* hdl/nvs_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
// Assumes inputs may change at any time relative to clk_in
module nvs_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // Levels
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    // ==================================================================
    // Two stages
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= IDLE;
            q_out  <= IDLE;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule

/* hdl/nvs_seq.sv */
// Store/recall sequencer of a serial nonvolatile SRAM
// Assumes supply monitor, store/busy pin and bus lines are asynchronous;
// commands and write strobes come from logic on clk_in
module nvs_seq
    import nvs_pkg::*;
#(
    parameter bit LOW_V       = 1'b0,
    parameter int CNT_W       = 21,
    parameter int FA_CYC      = C_FA_CYC,
    parameter int FA_LV_CYC   = C_FA_LV_CYC,
    parameter int STORE_CYC   = C_STORE_CYC,
    parameter int RECALL_CYC  = C_RECALL_CYC,
    parameter int WAKE_CYC    = C_WAKE_CYC,
    parameter int WAKE_LV_CYC = C_WAKE_LV_CYC,
    parameter int SLEEP_CYC   = C_SLEEP_CYC,
    parameter int SB_CYC      = C_SB_CYC
) (
    // Clock and reset
    input  wire logic      clk_in,
    input  wire logic      rst_in,
    // Supply monitor, high above trip level
    input  wire logic      supply_ok_in,
    // Bus lines, sampled only
    input  wire logic      scl_in,
    input  wire logic      sda_in,
    // Commands and SRAM write strobe
    input  wire nvs_cmd_t  cmd_in,
    input  wire logic      sram_write_in,
    // Store/busy pin
    input  wire logic      store_busy_pin_in,
    output logic           store_busy_pin_out,
    output logic           store_busy_pin_oe_out,
    // Status
    output nvs_stat_t      stat_out
);
    localparam int FA_SEL   = LOW_V ? FA_LV_CYC : FA_CYC;
    localparam int WAKE_SEL = LOW_V ? WAKE_LV_CYC : WAKE_CYC;
    localparam int A_HHHD   = C_HHHD_CYC;
    // Idle levels of the lanes, so no false edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = (SYNC_W'(1) << LANE_PIN) |
                                              (SYNC_W'(1) << LANE_SCL) |
                                              (SYNC_W'(1) << LANE_SDA);

    // ==================================================================
    // Elaboration checks
    if (FA_LV_CYC >= 2 ** CNT_W || WAKE_LV_CYC >= 2 ** CNT_W ||
        STORE_CYC >= 2 ** CNT_W || SB_CYC < 3 || FA_CYC < 1 ||
        FA_CYC >= 2 ** CNT_W || WAKE_CYC >= 2 ** CNT_W ||
        RECALL_CYC >= 2 ** CNT_W || SLEEP_CYC >= 2 ** CNT_W ||
        FA_LV_CYC < 1 || WAKE_CYC < 1 || WAKE_LV_CYC < 1 ||
        STORE_CYC < 1 || RECALL_CYC < 1 || SLEEP_CYC < 1) begin : g_chk
        $error("nvs_seq: counter too narrow or count too small");
    end

    nvs_state_t       state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [SYNC_W-1:0] sync_s;
    logic             supply_s, pin_s, scl_s, sda_s, sda_d_r;
    logic             pend_r, stop_det, start_det, wr_ok;

    // ==================================================================
    // Input synchronisation
    nvs_sync #(.W(SYNC_W), .IDLE(SYNC_IDLE)) u_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   ({sda_in, scl_in, store_busy_pin_in, supply_ok_in}),
        .q_out  (sync_s)
    );

    assign supply_s  = sync_s[LANE_SUP];
    assign pin_s     = sync_s[LANE_PIN];
    assign scl_s     = sync_s[LANE_SCL];
    assign sda_s     = sync_s[LANE_SDA];
    assign stop_det  = scl_s && sda_s && !sda_d_r;
    assign start_det = scl_s && !sda_s && sda_d_r;
    assign wr_ok     = sram_write_in && stat_out.sram_wen;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sda_d_r <= 1'b1;
        end else begin
            sda_d_r <= sda_s;
        end
    end

    // ==================================================================
    // Write-pending flag, set wins over clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend_r <= 1'b0;
        end else if (wr_ok) begin
            pend_r <= 1'b1;
        end else if ((state_r == S_STORE || state_r == S_RECALL) && cnt_r == '0) begin
            pend_r <= 1'b0;
        end
    end

    // ==================================================================
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
        unique case (state_r)
            S_PWRDN: begin
                if (supply_s) begin
                    state_nxt = S_RECALL;
                    cnt_nxt   = CNT_W'(FA_SEL - 1);
                end
            end
            S_RECALL: begin
                if (!supply_s) begin
                    state_nxt = S_PWRDN;
                end else if (cnt_r == '0) begin
                    state_nxt = S_READY;
                end
            end
            S_DELAY: begin
                if (cnt_r == '0) begin
                    state_nxt = S_STORE;
                    cnt_nxt   = CNT_W'(STORE_CYC - 1);
                end
            end
            S_STORE: begin
                if (cnt_r == '0) begin
                    state_nxt = supply_s ? S_HIGH : S_PWRDN;
                    cnt_nxt   = CNT_W'(C_HHHD_CYC - 1);
                end
            end
            S_HIGH: begin
                if (cnt_r == '0) begin
                    state_nxt = S_PINWAIT;
                end
            end
            S_PINWAIT: begin
                if (pin_s) begin
                    state_nxt = S_READY;
                end
            end
            S_SLP_ENTER: begin
                if (cnt_r == '0) begin
                    state_nxt = S_SLEEP;
                end
            end
            S_SLEEP: begin
                if (cmd_in.wake) begin
                    state_nxt = S_WAKE;
                    cnt_nxt   = CNT_W'(WAKE_SEL - 1);
                end
            end
            S_WAKE: begin
                if (cnt_r == '0) begin
                    state_nxt = S_READY;
                end
            end
            S_READY: begin
                if (!pin_s) begin
                    state_nxt = pend_r ? S_DELAY : S_PINWAIT;
                    cnt_nxt   = CNT_W'(C_DELAY_CYC - 1);
                end else if (cmd_in.store) begin
                    state_nxt = S_STORE;
                    cnt_nxt   = CNT_W'(STORE_CYC - 1);
                end else if (cmd_in.recall) begin
                    state_nxt = S_RECALL;
                    cnt_nxt   = CNT_W'(RECALL_CYC - 1);
                end else if (cmd_in.sleep) begin
                    state_nxt = S_SLP_ENTER;
                    cnt_nxt   = CNT_W'(SLEEP_CYC - 1);
                end
            end
        endcase
        // Supply loss overrides idle-like states
        if (!supply_s && (state_r == S_READY || state_r == S_PINWAIT ||
            state_r == S_SLP_ENTER || state_r == S_SLEEP || state_r == S_WAKE)) begin
            state_nxt = pend_r ? S_DELAY : S_PWRDN;
            cnt_nxt   = CNT_W'(C_DELAY_CYC - 1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= S_PWRDN;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ==================================================================
    // Host gating and status
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stat_out.host_en   <= 1'b0;
            stat_out.sram_wen  <= 1'b0;
            stat_out.busy      <= 1'b0;
            stat_out.low_power <= 1'b0;
        end else begin
            stat_out.host_en   <= state_r == S_READY && supply_s && pin_s;
            stat_out.sram_wen  <= (state_r == S_READY && supply_s && pin_s) ||
                                  state_r == S_DELAY;
            stat_out.busy      <= state_r == S_STORE || state_r == S_RECALL ||
                                  state_r == S_DELAY;
            stat_out.low_power <= state_r == S_SLEEP;
        end
    end

    // ==================================================================
    // Standby after STOP
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stat_out.standby <= 1'b0;
        end else if (state_r != S_READY || start_det) begin
            stat_out.standby <= 1'b0;
        end else if (stop_det) begin
            stat_out.standby <= 1'b1;
        end
    end

    // ==================================================================
    // Store/busy pin driver
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            store_busy_pin_out    <= 1'b1;
            store_busy_pin_oe_out <= 1'b0;
        end else begin
            store_busy_pin_oe_out <= state_r == S_DELAY || state_r == S_STORE ||
                                     state_r == S_HIGH;
            store_busy_pin_out    <= state_r == S_HIGH;
        end
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_store_end;
        state_r == S_STORE && state_nxt == S_HIGH;
    endsequence

    sequence s_high_release;
        state_r == S_HIGH [*1] ##[1:A_HHHD] state_r == S_PINWAIT;
    endsequence

    a_host_off_op: assert property (
        (state_r == S_STORE || state_r == S_RECALL) |=> !stat_out.host_en)
        else $error("host enabled during store or recall");
    a_host_off_supply: assert property (
        !supply_s |=> !stat_out.host_en && !stat_out.sram_wen ||
        $past(state_r) == S_DELAY)
        else $error("host enabled while supply low");
    a_skip_clean: assert property (
        state_r == S_READY && !pin_s && !pend_r && supply_s |=> state_r == S_PINWAIT ##1
        !store_busy_pin_oe_out)
        else $error("save not skipped or pin driven");
    a_delay_wen: assert property (
        state_r == S_DELAY |=> stat_out.sram_wen && store_busy_pin_oe_out)
        else $error("writes not kept enabled at save start");
    a_high_bound: assert property (
        s_store_end |=> s_high_release)
        else $error("pin driven high too long");
    a_pin_lockout: assert property (
        !pin_s && !store_busy_pin_oe_out |=> !stat_out.host_en)
        else $error("access enabled while pin held low");
    a_pin_resume: assert property (
        state_r == S_PINWAIT && pin_s && supply_s && $past(supply_s)
        |-> ##[1:3] stat_out.host_en || !supply_s)
        else $error("host not resumed after pin high");
    a_cmd_act: assert property (
        state_r == S_READY && pin_s && supply_s && cmd_in.store |=>
        state_r == S_STORE ##1 stat_out.busy && !stat_out.host_en)
        else $error("store command not acted on");
    a_pend_set: assert property (
        wr_ok |=> pend_r)
        else $error("write did not set pending flag");
    a_sleep_time: assert property (
        state_r == S_SLP_ENTER && cnt_r == '0 && supply_s |=> state_r == S_SLEEP ##1
        stat_out.low_power)
        else $error("sleep entry exceeds limit");
    a_recall_time: assert property (
        state_r == S_RECALL && cnt_r == '0 && supply_s |=> state_r == S_READY ##1
        !stat_out.busy)
        else $error("recall exceeds limit");
    a_standby_stop: assert property (
        state_r == S_READY && stop_det && !start_det |=> stat_out.standby)
        else $error("standby not entered after stop");
endmodule

/* dv/nvs_far_model.sv */
// Far-side model: bus master lines and external store/busy pin driver
// Assumes the bench resolves the pin wire with its pull-up
module nvs_far_model (
    // Wire drives
    output logic ext_low_out,
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ext_low_out = 1'h0;
        scl_out     = 1'h1;
        sda_out     = 1'h1;
    end

    // ==================================================================
    // Save request on the pin, held above the minimum
    task automatic pull_pin(input int ns);
        ext_low_out = 1'h1;
        #((ns < 60) ? 60 : ns);
        ext_low_out = 1'h0;
    endtask

    // ==================================================================
    // One byte between START and STOP, clock still outside the frame
    task automatic send_frame(input logic [7:0] b);
        sda_out = 1'h0;
        #80 scl_out = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            sda_out = b[i];
            #80 scl_out = 1'h1;
            #80 scl_out = 1'h0;
        end
        sda_out = 1'h0;
        #80 scl_out = 1'h1;
        #80 sda_out = 1'h1;
    endtask
endmodule

/* dv/nvs_seq_tb.sv */
// Self-checking bench of the store/recall sequencer
// Assumes shortened counts; pin wire has a pull-up
module nvs_seq_tb
    import nvs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int P_FA = 40;
    localparam int P_ST = 50;
    localparam int P_RC = 30;
    localparam int P_WK = 40;
    localparam int P_SL = 30;
    localparam int HI   = C_HHHD_CYC + 6;

    logic        clk_in;
    logic        rst_in;
    logic        supply_ok_in;
    logic        sram_write_in;
    nvs_cmd_t    cmd_in;
    logic        pin_out;
    logic        pin_oe;
    logic        pin_w;
    nvs_stat_t   stat_out;
    wire         ext_low;
    wire         scl;
    wire         sda;
    int          n_errors;
    int          total_checks;
    int          bcnt;
    int          exp_lo[$];
    int          exp_hi[$];
    logic        mon_on;
    logic [31:0] rnd;

    assign pin_w = pin_oe ? pin_out : (ext_low ? 1'h0 : 1'h1);

    initial begin
        clk_in = 1'h0;
        forever #10 clk_in = ~clk_in;
    end

    nvs_far_model i_nvs_far_model (.ext_low_out(ext_low), .scl_out(scl), .sda_out(sda));

    nvs_seq #(.LOW_V(1'b1), .FA_CYC(P_FA / 2), .FA_LV_CYC(P_FA), .STORE_CYC(P_ST),
              .RECALL_CYC(P_RC), .WAKE_CYC(P_WK / 2), .WAKE_LV_CYC(P_WK),
              .SLEEP_CYC(P_SL)) i_nvs_seq (
        .clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(supply_ok_in),
        .scl_in(scl), .sda_in(sda), .cmd_in(cmd_in), .sram_write_in(sram_write_in),
        .store_busy_pin_in(pin_w), .store_busy_pin_out(pin_out),
        .store_busy_pin_oe_out(pin_oe), .stat_out(stat_out));

    // ==================================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic sel(input int k);
        case (k)
            0: return stat_out.host_en;
            1: return stat_out.busy;
            2: return stat_out.low_power;
            3: return stat_out.standby;
            4: return pin_oe;
            default: return pin_oe & pin_out;
        endcase
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask

    task automatic report_and_stop;
        if (exp_lo.size() != 0) begin
            n_errors++;
            $display("[ERR] busy_pulses expected 0 left seen %0d left", exp_lo.size());
        end
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check_bit(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic check_range(input string nm, input int lo, input int hi, input int s);
        total_checks++;
        if (s < lo || s > hi) begin
            n_errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, s);
        end
    endtask

    task automatic wait_for(input int k, input logic lvl, input int lim, output int n);
        n = 0;
        while (sel(k) !== lvl) begin
            if (n >= lim) begin
                n_errors++;
                $display("[ERR] wait_%0d expected %b seen timeout", k, lvl);
                report_and_stop();
            end
            step(1);
            n++;
        end
    endtask

    task automatic cmd(input nvs_cmd_t c);
        cmd_in = c;
        step(1);
        cmd_in = '0;
    endtask

    task automatic write_once;
        sram_write_in = 1'h1;
        step(1);
        sram_write_in = 1'h0;
    endtask

    task automatic expect_busy(input int lo, input int hi);
        exp_lo.push_back(lo);
        exp_hi.push_back(hi);
    endtask

    // ==================================================================
    // Monitor of busy pulse lengths
    always @(posedge clk_in) begin
        if (mon_on !== 1'h1)
            bcnt <= 0;
        else if (stat_out.busy === 1'h1)
            bcnt <= bcnt + 1;
        else if (bcnt != 0) begin
            if (exp_lo.size() == 0)
                check_range("busy_unexpected", 0, -1, bcnt);
            else
                check_range("busy_len", exp_lo.pop_front(), exp_hi.pop_front(), bcnt);
            bcnt <= 0;
        end
    end

    // ==================================================================
    // Main sequence
    initial begin
        int n;
        rnd = 32'h0000_c15b;
        n_errors = 0;
        total_checks = 0;
        mon_on = 1'h0;
        rst_in = 1'h1;
        supply_ok_in = 1'h0;
        sram_write_in = 1'h0;
        cmd_in = '0;
        step(10);
        rst_in = 1'h0;
        step(3);
        check_bit("host_en_no_supply", 1'h0, stat_out.host_en);
        supply_ok_in = 1'h1;
        wait_for(0, 1'h1, P_FA + 20, n);
        check_range("powerup", P_FA, P_FA + 8, n);
        mon_on = 1'h1;
        // Pin request with nothing written
        rnd = xs(rnd);
        fork i_nvs_far_model.pull_pin(60 + int'(rnd[5:0])); join_none
        step(4);
        check_bit("host_en_pin_low", 1'h0, stat_out.host_en);
        check_bit("sram_wen_pin_low", 1'h0, stat_out.sram_wen);
        check_bit("oe_skip", 1'h0, pin_oe);
        wait_for(0, 1'h1, C_LZHSB_CYC + 10, n);
        check_range("host_back", 0, C_LZHSB_CYC, n);
        // Pin request after a write
        write_once();
        expect_busy(P_ST, P_ST + HI);
        fork i_nvs_far_model.pull_pin(60); join_none
        wait_for(4, 1'h1, 8, n);
        check_bit("wen_in_delay", 1'h1, stat_out.sram_wen);
        wait_for(5, 1'h1, P_ST + 10, n);
        wait_for(4, 1'h0, HI, n);
        check_range("high_drive", 1, C_HHHD_CYC, n);
        wait_for(0, 1'h1, C_LZHSB_CYC + 10, n);
        check_range("host_after_store", 0, C_LZHSB_CYC, n);
        // Flag cleared: a second request is skipped
        fork i_nvs_far_model.pull_pin(80); join_none
        step(8);
        check_bit("oe_after_clear", 1'h0, pin_oe);
        wait_for(0, 1'h1, C_LZHSB_CYC + 10, n);
        // Commanded store, recall during it is dropped, then recall
        rnd = xs(rnd);
        step(1 + int'(rnd[2:0]));
        expect_busy(P_ST, P_ST + HI);
        cmd(4'h8);
        wait_for(1, 1'h1, 4, n);
        check_range("cmd_react", 0, 3, n);
        step(10);
        check_bit("host_en_busy", 1'h0, stat_out.host_en);
        cmd(4'h4);
        wait_for(0, 1'h1, P_ST + HI + C_LZHSB_CYC, n);
        expect_busy(P_RC, P_RC + 4);
        cmd(4'h4);
        step(3);
        wait_for(0, 1'h1, P_RC + 40, n);
        // Sleep and wake
        cmd(4'h2);
        wait_for(2, 1'h1, P_SL + 10, n);
        check_range("sleep_entry", P_SL - 2, P_SL + 4, n);
        cmd(4'h1);
        wait_for(0, 1'h1, P_WK + 20, n);
        check_range("wake", P_WK - 2, P_WK + 8, n);
        check_bit("low_power_wake", 1'h0, stat_out.low_power);
        // Bus frame then standby
        rnd = xs(rnd);
        i_nvs_far_model.send_frame(rnd[7:0]);
        step(1);
        wait_for(3, 1'h1, C_SB_CYC, n);
        check_range("standby", 0, C_SB_CYC, n);
        // Supply loss with a pending write
        write_once();
        expect_busy(P_ST, P_ST + HI);
        supply_ok_in = 1'h0;
        step(4);
        check_bit("host_en_supply_low", 1'h0, stat_out.host_en);
        wait_for(1, 1'h0, P_ST + HI + 10, n);
        step(2);
        mon_on = 1'h0;
        supply_ok_in = 1'h1;
        wait_for(0, 1'h1, P_FA + 20, n);
        check_range("repowerup", P_FA, P_FA + 8, n);
        // Supply loss with nothing written
        mon_on = 1'h1;
        supply_ok_in = 1'h0;
        step(P_ST + HI);
        check_bit("busy_clean_loss", 1'h0, stat_out.busy);
        check_bit("host_en_clean_loss", 1'h0, stat_out.host_en);
        check_bit("oe_clean_loss", 1'h0, pin_oe);
        report_and_stop();
    end
endmodule
